//--- bench/panel_model.sv
// Panel and supply model: frames, polarity, event times.
// Assumes pins change only just after MCLK edges.
module panel_model
    import panel_seq_pkg::*;
#(
    parameter int RISE = 40
) (
    input  wire logic        MCLK,
    input  wire panel_pins_t PANEL,
    input  wire logic        SUPPLY_EN,
    output logic             SUPPLY_GOOD = 0,
    output logic [15:0]      last_frame,
    output int               clears = 0,
    output int               frames = 0,
    output int               toggles = 0,
    output logic             polarity = 0,
    output time              t_show,
    output time              t_cs_rise,
    output time              t_cs_fall,
    output time              t_cs1,
    output time              t_off,
    output time              t_good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh;
    int          up = 0;
    logic        first = 0;
    // ==========
    // Supply answers late; show, chip select and supply event times are recorded
    always @(posedge MCLK) begin
        up <= SUPPLY_EN ? up + 1 : 0;
        SUPPLY_GOOD <= SUPPLY_EN && up >= RISE;
    end
    always @(posedge SUPPLY_GOOD) t_good = $time;
    always @(negedge SUPPLY_EN) t_off = $time;
    always @(posedge PANEL.panel_show_pin) begin
        t_show = $time;
        first = 1;
    end
    always @(posedge PANEL.panel_chip_select) begin
        t_cs_rise = $time;
        sh = 0;
        if (first) t_cs1 = $time;
        first = 0;
    end
    always @(posedge PANEL.sclk) sh = {sh[14:0], PANEL.si};
    always @(negedge PANEL.panel_chip_select) begin
        t_cs_fall = $time;
        last_frame = sh;
        frames++;
        if (!sh[15] && sh[13]) clears++;
        else if (!PANEL.polarity_source_select) polarity = sh[14];
    end
    // Pulses while the show pin is low are ignored
    always @(posedge PANEL.polarity_toggle_in) begin
        if (PANEL.polarity_source_select && PANEL.panel_show_pin) toggles++;
    end
endmodule

//--- bench/panel_power_seq_bench.sv
// Bench: register access, two power cycles, frame and wait checks.
// Assumes the monitor bind and panel_model.
`include "panel_seq_consts.svh"
module panel_power_seq_bench
    import panel_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK = 0, RST = 1, SUPPLY_GOOD, SUPPLY_EN, polarity, S_AXI_AWREADY;
    logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_WREADY;
    logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [7:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d, v;
    logic [3:0]  S_AXI_WSTRB = 4'hf;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
    logic [15:0] last_frame;
    logic        p;
    panel_pins_t PANEL;
    int          bad_count = 0, checked = 0, clears, frames, toggles, seed = 73, ec = 0, m, n;
    time         t_show, t_cs_rise, t_cs_fall, t_cs1, t_off, t_good, t_run;
    panel_power_seq #(.SIMUL_WAIT(20)) i_panel_power_seq (.*);
    panel_model i_panel_model (.*);
    initial forever #5 MCLK = ~MCLK;
    // ==========
    // Shared tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic waitfor(ref logic s, input int lim);
        int k;
        k = 0;
        do begin @(posedge MCLK); k++; end while (s !== 1'b1 && k < lim);
        if (s !== 1'b1) begin cmp(s, 1); tally_and_finish(); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [1:0] e);
        @(posedge MCLK);
        S_AXI_AWADDR <= a; S_AXI_WDATA <= w;
        S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1; S_AXI_BREADY <= 1;
        waitfor(S_AXI_AWREADY, 50);
        S_AXI_AWVALID <= 0; S_AXI_WVALID <= 0;
        waitfor(S_AXI_BVALID, 50);
        S_AXI_BREADY <= 0;
        cmp(S_AXI_BRESP, e);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
        waitfor(S_AXI_ARREADY, 50);
        S_AXI_ARVALID <= 0;
        waitfor(S_AXI_RVALID, 50);
        S_AXI_RREADY <= 0; d = S_AXI_RDATA; r = S_AXI_RRESP;
    endtask
    task automatic poll(input logic [2:0] st);
        int k;
        for (k = 0; k < 6000 && (k == 0 || d[6:4] !== st); k++) rd(`OFS_STATUS);
        t_run = $time;
        cmp(d[6:4], st);
        if (d[6:4] !== st) tally_and_finish();
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 0;
        rd(`OFS_COM_HALF); cmp(d, `COM_HALF_RST);
        rd(8'h0c); cmp({r, d}, {2'b10, 32'h0});
        wr(8'h10, 32'h1, 2'b10);
        rd(`OFS_STATUS); cmp(d, 0);
        repeat (3) begin
            v = 32'd2200 + ($random(seed) & 32'h1ff);
            wr(`OFS_COM_HALF, v, 2'b00);
            rd(`OFS_COM_HALF); cmp(d, v);
        end
        for (m = 0; m < 2; m++) begin
            wr(`OFS_CTRL, {28'h0, m[0], ~m[0], 2'b01}, 2'b00);
            poll(3'b111); cmp(d[0], 1);
            cmp(clears, ec + 1);
            cmp({last_frame[15], last_frame[13:0]}, 15'h2000);
            cmp(PANEL.polarity_source_select, !m[0]);
            cmp(t_cs_rise > t_good && t_show > t_cs_fall, 1);
            if (m == 0) cmp(t_run - t_show >= 60000 && toggles > 0, 1);
            else begin
                for (n = 0; n < 9000 && frames < ec + 2; n++) @(posedge MCLK);
                p = last_frame[14];
                for (n = 0; n < 9000 && frames < ec + 3; n++) @(posedge MCLK);
                cmp({last_frame[15], last_frame[13], last_frame[14]}, {2'b00, ~p});
                cmp(t_cs1 - t_show >= 200, 1);
            end
            wr(`OFS_CTRL, {28'h0, m[0], ~m[0], 2'b10}, 2'b00);
            poll(3'b000); cmp(d[1:0], 2'b10);
            cmp(clears, ec + 2);
            cmp(t_off - t_cs_fall >= 30000, 1);
            ec = frames;
            $display("Power cycle %0d done", m);
        end
        tally_and_finish();
    end
endmodule

//--- bench/panel_power_seq_monitor.sv
// Port assertions for the panel power sequencer.
// Assumes one clock MCLK and RST asynchronous, active high.
module panel_power_seq_monitor
    import panel_seq_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        SUPPLY_EN,
    input wire panel_pins_t PANEL
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // ==========
    // Bus and pins
    chk_write_answer: assert property (S_AXI_AWREADY |=> S_AXI_BVALID) else $error("late b");
    chk_bvalid_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("b dropped");
    chk_read_answer: assert property (S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late r");
    chk_pins_unpowered: assert property (!SUPPLY_EN |-> !(PANEL.panel_show_pin
        || PANEL.panel_chip_select || PANEL.polarity_toggle_in)) else $error("pin live");
    chk_sclk_framed: assert property (PANEL.sclk |-> PANEL.panel_chip_select)
        else $error("sclk unframed");
    chk_select_setup: assert property ($rose(PANEL.panel_chip_select) |-> !PANEL.sclk[*8])
        else $error("short setup");
    chk_select_gap: assert property ($fell(PANEL.panel_chip_select)
        |-> !PANEL.panel_chip_select[*8]) else $error("short gap");
    chk_toggle_shown: assert property ($rose(PANEL.polarity_toggle_in)
        |-> PANEL.panel_show_pin) else $error("toggle unshown");
    cover property ($rose(PANEL.panel_show_pin));
    cover property ($fell(SUPPLY_EN));
    cover property ($rose(PANEL.polarity_toggle_in));
endmodule
bind panel_power_seq panel_power_seq_monitor i_panel_power_seq_monitor (.*);

//--- hw/frame_sender.sv
// Sends one 16-clock command frame to the panel: three mode bits, then dummy zeros.
// Assumes start is a one-cycle pulse from the same clock, taken only when idle.
`include "panel_seq_consts.svh"
module frame_sender
    import panel_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  frame_mode_t      mode,
    output ser_pins_t        pins,
    output logic             busy,
    output logic             done
);
    ser_state_t   state_ff;
    logic [15:0]  cnt_ff;
    logic [15:0]  shreg_ff;
    logic [5:0]   edges_ff;
    wire          cnt_zero = (cnt_ff == 16'h0000);
    wire          take     = start && (state_ff == SR_IDLE);

    assign busy = (state_ff != SR_IDLE);

    // ======================================================================
    // Frame timing: select setup, half clock periods, hold, low width
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= SR_IDLE;
            cnt_ff   <= 16'h0000;
            shreg_ff <= 16'h0000;
            edges_ff <= 6'h00;
            pins     <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_ff)
                SR_IDLE: begin
                    if (take) begin
                        // Mode bits go out first, the rest stay low as dummy
                        shreg_ff <= {mode, 13'h0000};
                        pins.si <= mode.update_flag;
                        pins.panel_chip_select <= 1'b1;
                        cnt_ff   <= 16'(`SER_SETUP_CYC - 1);
                        state_ff <= SR_SETUP;
                    end
                end
                SR_SETUP: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_zero) begin
                        cnt_ff   <= 16'(`SER_HALF_CYC - 1);
                        edges_ff <= 6'(2 * `SER_BITS);
                        state_ff <= SR_SHIFT;
                    end
                end
                SR_SHIFT: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_zero) begin
                        cnt_ff    <= 16'(`SER_HALF_CYC - 1);
                        edges_ff  <= edges_ff - 6'h01;
                        pins.sclk <= ~pins.sclk;
                        // Data change on the falling edge, panel samples on rising
                        if (pins.sclk) begin
                            shreg_ff <= {shreg_ff[14:0], 1'b0};
                            pins.si  <= shreg_ff[14];
                        end
                        if (edges_ff == 6'h01) begin
                            cnt_ff   <= 16'(`SER_HOLD_CYC - 1);
                            state_ff <= SR_HOLD;
                        end
                    end
                end
                SR_HOLD: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_zero) begin
                        pins     <= '0;
                        cnt_ff   <= 16'(`SER_LOW_CYC - 1);
                        state_ff <= SR_GAP;
                    end
                end
                SR_GAP: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_zero) begin
                        done     <= 1'b1;
                        state_ff <= SR_IDLE;
                    end
                end
                default: begin
                    pins     <= '0;
                    state_ff <= SR_IDLE;
                end
            endcase
        end
    end
endmodule

//--- hw/panel_power_seq.sv
// Power-on and power-off sequencer for a memory display panel, AXI4-Lite controlled.
// Assumes supplies are switched by SUPPLY_EN and report back on SUPPLY_GOOD.
//
// Functional notes
// - Source select high: panel inverts polarity from the toggle input.
// - Source select low: panel inverts polarity from the serial polarity flag.
// - After supplies rise, host clears pixel memory with the clear-all command.
// - Host allows 30 us after clearing for the polarity latch release.
// - Host allows 30 us for polarity initialisation before normal operation.
// - Release and polarity steps in either order; toggles ignored while show low.
// - Show pin and toggle started together: 100 us before chip select.
// - At power-off the host first clears pixel memory the same way.
// - After power-off clearing, host waits 30 us before supplies fall.
// - Clearing uses normal chip select and serial clock driving.
// - Clear-all frame: update flag low, clear-all flag high.
// - Host keeps toggle frequency below the frame frequency.
`include "panel_seq_consts.svh"
module panel_power_seq
    import panel_seq_pkg::*;
#(
    parameter int unsigned SIMUL_WAIT = `SIMUL_WAIT_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        SUPPLY_GOOD,
    output logic             SUPPLY_EN,
    output panel_pins_t      PANEL
);
    // ======================================================================
    // Declarations
    seq_state_t   state_ff;
    seq_state_t   nxt_state;
    logic [31:0]  timer_ff;
    logic [31:0]  com_half_ff;
    logic [31:0]  com_cnt_ff;
    logic         common_electrode_level_ff;
    logic         src_ff;
    logic         simul_ff;
    logic         on_req_ff;
    logic         off_req_ff;
    logic         on_done_ff;
    logic         off_done_ff;
    logic         issued_ff;
    logic         show_ff;
    logic         tog_ff;
    logic         supply_ok;
    ser_pins_t    ser_pins;
    logic         ser_busy;
    logic         ser_done;

    // ======================================================================
    // Bus decode
    wire          wr_take   = S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WVALID;
    wire          wr_go     = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY
                              && !S_AXI_BVALID;
    wire          rd_take   = S_AXI_ARREADY && S_AXI_ARVALID;
    wire          rd_go     = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
    wire          wr_ctrl   = wr_take && (S_AXI_AWADDR == `OFS_CTRL) && S_AXI_WSTRB[0];
    wire          wr_com    = wr_take && (S_AXI_AWADDR == `OFS_COM_HALF);
    wire          wr_status = (S_AXI_AWADDR == `OFS_STATUS);
    wire          wr_ok     = wr_status || (S_AXI_AWADDR == `OFS_CTRL)
                              || (S_AXI_AWADDR == `OFS_COM_HALF);
    wire          rd_ctrl   = (S_AXI_ARADDR == `OFS_CTRL);
    wire          rd_status = (S_AXI_ARADDR == `OFS_STATUS);
    wire          rd_com    = (S_AXI_ARADDR == `OFS_COM_HALF);
    wire          rd_ok     = rd_ctrl || rd_status || rd_com;
    wire [31:0]   com_wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                               {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    wire [31:0]   ctrl_word = {28'h0000000, simul_ff, src_ff, 2'b00};
    wire [31:0]   stat_word = {25'h0000000, state_ff, supply_ok,
                               (state_ff != SQ_IDLE), off_done_ff, on_done_ff};
    wire [31:0]   rd_word   = rd_ctrl ? ctrl_word : rd_status ? stat_word
                              : rd_com ? com_half_ff : 32'h00000000;

    // ======================================================================
    // Sequencer decode
    wire          timer_zero = (timer_ff == 32'h00000000);
    wire          clr_state  = (state_ff == SQ_ON_CLEAR) || (state_ff == SQ_OFF_CLR);
    // Panel ignores toggles while the show pin is low, so the toggle runs after release, or from the show pin rise when simul_ff is set
    wire          pol_run    = (state_ff == SQ_POLINIT) || (state_ff == SQ_RUN)
                               || ((state_ff == SQ_LATCH) && simul_ff)
                               || (state_ff == SQ_OFF_CLR) || (state_ff == SQ_OFF_WAIT);
    wire          com_tick   = pol_run && (com_cnt_ff == 32'h00000000);
    wire          run_show   = (state_ff != SQ_IDLE) && (state_ff != SQ_SUPPLY)
                               && (state_ff != SQ_ON_CLEAR);
    wire          clr_start  = clr_state && !issued_ff && !ser_busy;
    // Serial polarity frames only when the panel takes polarity from the flag
    wire          pol_start  = (state_ff == SQ_RUN) && !src_ff && com_tick
                               && !ser_busy;
    wire          ser_start  = clr_start || pol_start;
    wire          clr_done   = clr_state && issued_ff && ser_done;
    // Clear-all: update flag low, clear-all flag high; else a plain display frame
    wire frame_mode_t ser_mode = {1'b0, common_electrode_level_ff, clr_state};
    wire          seq_move   = (nxt_state != state_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SQ_IDLE:     if (on_req_ff) nxt_state = SQ_SUPPLY;
            // Nothing moves on the pins until the supply reports good
            SQ_SUPPLY:   if (off_req_ff) nxt_state = SQ_IDLE;
                         else if (supply_ok) nxt_state = SQ_ON_CLEAR;
            SQ_ON_CLEAR: if (clr_done) nxt_state = SQ_LATCH;
            SQ_LATCH:    if (timer_zero) nxt_state = simul_ff ? SQ_RUN : SQ_POLINIT;
            SQ_POLINIT:  if (timer_zero) nxt_state = SQ_RUN;
            SQ_RUN:      if (off_req_ff) nxt_state = SQ_OFF_CLR;
            SQ_OFF_CLR:  if (clr_done) nxt_state = SQ_OFF_WAIT;
            SQ_OFF_WAIT: if (timer_zero) nxt_state = SQ_IDLE;
            default:     nxt_state = SQ_IDLE;
        endcase
    end

    // ======================================================================
    // Bus slave
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'b00;
        end else begin
            S_AXI_AWREADY <= wr_go;
            S_AXI_WREADY  <= wr_go;
            if (wr_take) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? 2'b00 : 2'b10;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= 2'b00;
        end else begin
            S_AXI_ARREADY <= rd_go;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_word;
                S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Control registers; a request waits in its flag until the sequencer takes it
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            src_ff      <= `CTRL_SRC_RST;
            simul_ff    <= `CTRL_SIMUL_RST;
            com_half_ff <= `COM_HALF_RST;
            on_req_ff   <= 1'b0;
            off_req_ff  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                src_ff   <= S_AXI_WDATA[`CTRL_SRC_BIT];
                simul_ff <= S_AXI_WDATA[`CTRL_SIMUL_BIT];
            end
            if (wr_com) begin
                com_half_ff <= (S_AXI_WDATA & com_wmask) | (com_half_ff & ~com_wmask);
            end
            on_req_ff  <= (wr_ctrl && S_AXI_WDATA[`CTRL_ON_BIT])
                          || (on_req_ff && (state_ff != SQ_IDLE));
            off_req_ff <= (wr_ctrl && S_AXI_WDATA[`CTRL_OFF_BIT])
                          || (off_req_ff && (state_ff != SQ_RUN) && (state_ff != SQ_SUPPLY));
        end
    end

    // ======================================================================
    // Sequencer and wait timer
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_ff  <= SQ_IDLE;
            timer_ff  <= 32'h00000000;
            issued_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            issued_ff <= seq_move ? 1'b0 : (issued_ff || clr_start);
            if (seq_move) begin
                case (nxt_state)
                    // Waits rounded up to whole cycles, counted down to zero
                    SQ_LATCH:    timer_ff <= simul_ff ? 32'(SIMUL_WAIT - 1)
                                          : 32'(`LATCH_WAIT_CYC - 1);
                    SQ_POLINIT:  timer_ff <= 32'(`POLINIT_WAIT_CYC - 1);
                    SQ_OFF_WAIT: timer_ff <= 32'(`OFFLVL_WAIT_CYC - 1);
                    default:     timer_ff <= 32'h00000000;
                endcase
            end else if (!timer_zero) begin
                timer_ff <= timer_ff - 32'h00000001;
            end
        end
    end

    // ======================================================================
    // Done status: set on completion wins over the clear by a new request
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            on_done_ff  <= 1'b0;
            off_done_ff <= 1'b0;
        end else begin
            on_done_ff  <= (seq_move && (nxt_state == SQ_RUN))
                           || (on_done_ff && !(state_ff == SQ_RUN && off_req_ff));
            off_done_ff <= (seq_move && (nxt_state == SQ_IDLE) && (state_ff == SQ_OFF_WAIT))
                           || (off_done_ff && !(state_ff == SQ_IDLE && on_req_ff));
        end
    end

    // ======================================================================
    // Polarity timebase; the half period must keep the toggle below frame rate
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            com_cnt_ff <= 32'h00000000;
            common_electrode_level_ff    <= 1'b0;
        end else if (!pol_run) begin
            com_cnt_ff <= com_half_ff;
            common_electrode_level_ff    <= 1'b0;
        end else if (com_tick) begin
            com_cnt_ff <= com_half_ff;
            common_electrode_level_ff    <= ~common_electrode_level_ff;
        end else begin
            com_cnt_ff <= com_cnt_ff - 32'h00000001;
        end
    end

    // ======================================================================
    // Panel level pins
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SUPPLY_EN <= 1'b0;
            show_ff   <= 1'b0;
            tog_ff    <= 1'b0;
        end else begin
            // Supply drops on the same edge as the show and toggle pins go idle
            SUPPLY_EN <= (nxt_state != SQ_IDLE) || (state_ff != SQ_IDLE);
            show_ff   <= run_show;
            // Rising edges carry the polarity in external mode
            tog_ff    <= src_ff && pol_run && common_electrode_level_ff;
        end
    end

    assign PANEL.sclk                   = ser_pins.sclk;
    assign PANEL.si                     = ser_pins.si;
    assign PANEL.panel_chip_select      = ser_pins.panel_chip_select;
    assign PANEL.polarity_toggle_in     = tog_ff;
    assign PANEL.panel_show_pin         = show_ff;
    assign PANEL.polarity_source_select = src_ff;

    // ======================================================================
    // Submodules
    sync_two_ff u_sync (
        .clk  (MCLK),
        .rst  (RST),
        .din  (SUPPLY_GOOD),
        .dout (supply_ok)
    );

    // Clearing uses the normal chip select and clock timing
    frame_sender u_frame (
        .clk   (MCLK),
        .rst   (RST),
        .start (ser_start),
        .mode  (ser_mode),
        .pins  (ser_pins),
        .busy  (ser_busy),
        .done  (ser_done)
    );
endmodule

//--- hw/sync_two_ff.sv
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the level is slow against the clock.
module sync_two_ff (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    // ======================================================================
    // Only the second stage is visible to logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

//--- shared/panel_seq_consts.svh
// Offsets, field positions, reset values and timing counts of the panel power sequencer.
// Assumes a single 100 MHz clock; included by every design file that needs a number.
`ifndef PANEL_SEQ_CONSTS_SVH
`define PANEL_SEQ_CONSTS_SVH

// ==========================================================================
// Register map
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_COM_HALF      8'h08

// ==========================================================================
// Field positions
`define CTRL_ON_BIT       0
`define CTRL_OFF_BIT      1
`define CTRL_SRC_BIT      2
`define CTRL_SIMUL_BIT    3
`define ST_ON_DONE_BIT    0
`define ST_OFF_DONE_BIT   1
`define ST_BUSY_BIT       2
`define ST_SUPPLY_BIT     3
`define ST_STATE_LSB      4
`define ST_STATE_MSB      6

// ==========================================================================
// Reset values
`define CTRL_SRC_RST      1'b0
`define CTRL_SIMUL_RST    1'b0
`define COM_HALF_RST      32'h02faf080

// ==========================================================================
// Timing, in the unit printed, then in clock cycles rounded up
`define CLK_MHZ           100
`define NS_TO_CYC(ns)     (((ns) * `CLK_MHZ + 999) / 1000)
`define US_TO_CYC(us)     ((us) * `CLK_MHZ)
`define LATCH_WAIT_US     30
`define POLINIT_WAIT_US   30
`define OFFLVL_WAIT_US    30
`define SIMUL_WAIT_US     100
`define SER_HALF_NS       500
`define SER_SETUP_NS      3000
`define SER_HOLD_NS       1000
`define SER_LOW_NS        1000
`define LATCH_WAIT_CYC    `US_TO_CYC(`LATCH_WAIT_US)
`define POLINIT_WAIT_CYC  `US_TO_CYC(`POLINIT_WAIT_US)
`define OFFLVL_WAIT_CYC   `US_TO_CYC(`OFFLVL_WAIT_US)
`define SIMUL_WAIT_CYC    `US_TO_CYC(`SIMUL_WAIT_US)
`define SER_HALF_CYC      `NS_TO_CYC(`SER_HALF_NS)
`define SER_SETUP_CYC     `NS_TO_CYC(`SER_SETUP_NS)
`define SER_HOLD_CYC      `NS_TO_CYC(`SER_HOLD_NS)
`define SER_LOW_CYC       `NS_TO_CYC(`SER_LOW_NS)
`define SER_BITS          16

`endif

//--- shared/panel_seq_pkg.sv
// Types shared by the panel power sequencer and its serial frame sender.
// Assumes panel_seq_consts.svh for all numbers.
package panel_seq_pkg;

    // ======================================================================
    // Sequencer states Gray along the usual path; serial states too, except SR_GAP to SR_IDLE
    typedef enum logic [2:0] {
        SQ_IDLE     = 3'b000,
        SQ_SUPPLY   = 3'b001,
        SQ_ON_CLEAR = 3'b011,
        SQ_LATCH    = 3'b010,
        SQ_POLINIT  = 3'b110,
        SQ_RUN      = 3'b111,
        SQ_OFF_CLR  = 3'b101,
        SQ_OFF_WAIT = 3'b100
    } seq_state_t;

    typedef enum logic [2:0] {
        SR_IDLE  = 3'b000,
        SR_SETUP = 3'b001,
        SR_SHIFT = 3'b011,
        SR_HOLD  = 3'b010,
        SR_GAP   = 3'b110
    } ser_state_t;

    // ======================================================================
    // Pin groups
    typedef struct packed {
        logic sclk;
        logic si;
        logic panel_chip_select;
    } ser_pins_t;

    typedef struct packed {
        logic sclk;
        logic si;
        logic panel_chip_select;
        logic polarity_toggle_in;
        logic panel_show_pin;
        logic polarity_source_select;
    } panel_pins_t;

    // Mode bits of one frame: update_flag, polarity bit, clear_all_flag
    typedef struct packed {
        logic update_flag;
        logic polarity;
        logic clear_all_flag;
    } frame_mode_t;

endpackage
